// [rtl/pmroc_pkg.sv]
// shared constants and types for the port 1 sideband block
package pmroc_pkg;
   // ==========================================================
   // port modes
   typedef enum logic [2:0] {
      MODE_INTERNAL,
      MODE_MII_MAC,
      MODE_MII_PHY,
      MODE_RMII_MAC,
      MODE_RMII_PHY
   } pmroc_mode_t;
   localparam logic [2:0] MODE_LAST = 3'h4;
   // ==========================================================
   // register map, byte addresses
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_VPHY_BC = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_LPI_BIT = 3;
   localparam int STAT_MODE_LSB = 0;
   localparam int STAT_SPEED_BIT = 3;
   localparam int STAT_PIN_BIT = 4;
   localparam int STAT_POL_BIT = 5;
   localparam int STAT_MGMT_BUSY_BIT = 6;
   localparam int STAT_SYNCED_BIT = 7;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ==========================================================
   // virtual phy basic control
   localparam int BC_SPEED_BIT = 13;
   localparam int BC_AN_BIT = 12;
   localparam int BC_ISO_BIT = 10;
   localparam logic [15:0] BC_RESET = 16'h1000;
   localparam logic [15:0] RD_UNMAPPED = 16'h0000;
   localparam logic [4:0] VPHY_REG_BC = 5'h00;
   localparam logic [4:0] VPHY_ADDR_DEFAULT = 5'h01;
   // ==========================================================
   // management frame layout
   localparam logic [5:0] PREAMBLE_LEN = 6'h20;
   localparam logic [5:0] HDR_LAST = 6'h0B;
   localparam logic [5:0] DATA_LAST = 6'h0F;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_WRITE = 2'h1;
   // ==========================================================
   // link codes
   localparam logic [3:0] LPI_DATA = 4'h1;
   localparam logic [3:0] IDLE_DATA = 4'h0;
endpackage

// [rtl/pmroc_mgmt_if.sv]
// carrier between the port logic and the virtual phy management slave
`timescale 1ns/10ps
`default_nettype none
interface pmroc_mgmt_if;
   logic mdc_s;
   logic mdio_s;
   logic mdio_out;
   logic mdio_oe;
   logic active;
   logic [4:0] phy_addr;
   logic sw_write;
   logic [15:0] sw_data;
   logic [15:0] bc_value;
   logic busy;
   modport ctl (output mdc_s, output mdio_s, output active, output phy_addr,
      output sw_write, output sw_data, input mdio_out, input mdio_oe,
      input bc_value, input busy);
   modport vphy (input mdc_s, input mdio_s, input active, input phy_addr,
      input sw_write, input sw_data, output mdio_out, output mdio_oe,
      output bc_value, output busy);
endinterface
`default_nettype wire

// [rtl/pmroc_vphy_mdio.sv]
// clause 22 management slave holding the virtual phy basic control word
`timescale 1ns/10ps
`default_nettype none
module pmroc_vphy_mdio import pmroc_pkg::*; (
   // clock, reset, enable
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic ce,
   // port logic
   pmroc_mgmt_if.vphy mg
);
   typedef enum logic [2:0] {S_PRE, S_START, S_HDR, S_TA, S_DATA} pmroc_mdio_st_t;
   pmroc_mdio_st_t state_reg;
   logic [5:0] cnt_reg;
   logic [11:0] hdr_reg;
   logic [15:0] sh_reg;
   logic [15:0] bc_reg;
   logic mdc_d_reg;
   logic out_reg;
   logic oe_reg;
   logic rise;
   logic hit;
   logic drive;
   logic wr_commit;
   logic [15:0] rd_data;

   // ==========================================================
   // frame decode
   assign rise = mg.mdc_s & ~mdc_d_reg;
   assign hit = (hdr_reg[9:5] == mg.phy_addr);
   assign drive = hit & (hdr_reg[11:10] == OP_READ);
   assign rd_data = (hdr_reg[4:0] == VPHY_REG_BC) ? bc_reg : RD_UNMAPPED;
   assign wr_commit = mg.active & rise & (state_reg == S_DATA) & (cnt_reg == DATA_LAST)
      & hit & (hdr_reg[11:10] == OP_WRITE) & (hdr_reg[4:0] == VPHY_REG_BC);
   assign mg.bc_value = bc_reg;
   assign mg.mdio_out = out_reg;
   assign mg.mdio_oe = oe_reg;
   assign mg.busy = (state_reg != S_PRE);

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         mdc_d_reg <= 1'b0;
      end else if (ce) begin
         mdc_d_reg <= mg.mdc_s;
      end
   end

   // ==========================================================
   // basic control word; software write wins over a frame write
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         bc_reg <= BC_RESET;
      end else if (ce) begin
         if (mg.sw_write) begin
            bc_reg <= mg.sw_data;
         end else if (wr_commit) begin
            bc_reg <= {sh_reg[14:0], mg.mdio_s};
         end
      end
   end

   // ==========================================================
   // frame sequencer, one step per management clock rise
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         state_reg <= S_PRE;
         cnt_reg <= '0;
         hdr_reg <= '0;
         sh_reg <= '0;
         out_reg <= 1'b0;
         oe_reg <= 1'b0;
      end else if (ce) begin
         if (!mg.active) begin
            state_reg <= S_PRE;
            cnt_reg <= '0;
            oe_reg <= 1'b0;
         end else if (rise) begin
            case (state_reg)
               S_PRE: begin
                  if (mg.mdio_s) begin
                     if (cnt_reg != PREAMBLE_LEN) cnt_reg <= cnt_reg + 6'h01;
                  end else begin
                     if (cnt_reg == PREAMBLE_LEN) state_reg <= S_START;
                     cnt_reg <= '0;
                  end
               end
               S_START: begin
                  cnt_reg <= '0;
                  state_reg <= mg.mdio_s ? S_HDR : S_PRE;
               end
               S_HDR: begin
                  hdr_reg <= {hdr_reg[10:0], mg.mdio_s};
                  cnt_reg <= cnt_reg + 6'h01;
                  if (cnt_reg == HDR_LAST) begin
                     state_reg <= S_TA;
                     cnt_reg <= '0;
                  end
               end
               S_TA: begin
                  if (cnt_reg == '0) begin
                     cnt_reg <= 6'h01;
                     oe_reg <= drive;
                     out_reg <= 1'b0;
                  end else begin
                     state_reg <= S_DATA;
                     cnt_reg <= '0;
                     sh_reg <= rd_data;
                     out_reg <= rd_data[15];
                  end
               end
               S_DATA: begin
                  cnt_reg <= cnt_reg + 6'h01;
                  if (drive) begin
                     sh_reg <= {sh_reg[14:0], 1'b0};
                     out_reg <= sh_reg[14];
                  end else begin
                     sh_reg <= {sh_reg[14:0], mg.mdio_s};
                  end
                  if (cnt_reg == DATA_LAST) begin
                     state_reg <= S_PRE;
                     cnt_reg <= '0;
                     oe_reg <= 1'b0;
                  end
               end
               default: begin
                  state_reg <= S_PRE;
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// [rtl/pmroc_sideband.sv]
// port 1 mii/rmii sideband pins, speed selection and register slave
`timescale 1ns/10ps
`default_nettype none
module pmroc_sideband import pmroc_pkg::*; #(
   parameter int ADDR_W = 8,
   parameter logic [4:0] VPHY_ADDR = VPHY_ADDR_DEFAULT
) (
   // core clock domain
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic ce,
   // register slave, axi4-lite
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // straps and speed
   input wire logic [2:0] port1_mode_strap,
   input wire logic speed_pol_strap,
   input wire logic port1_speed_in,
   output logic speed_100,
   // link domain stream
   input wire logic link_clk,
   input wire logic tx_valid,
   input wire logic [3:0] tx_data,
   input wire logic tx_error,
   // link pins
   output logic port1_out_valid,
   output logic port1_out_valid_oe,
   output logic [3:0] port1_out_data,
   output logic port1_out_data_oe,
   output logic port1_out_error,
   output logic port1_out_error_oe,
   // management pins
   input wire logic port1_mgmt_clock,
   input wire logic port1_mgmt_data_in,
   output logic port1_mgmt_data_out,
   output logic port1_mgmt_data_oe
);
   if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr
      $error("ADDR_W must be 4 to 32");
   end

   // ==========================================================
   // helpers
   function automatic logic [7:0] word_of(input logic [ADDR_W-1:0] a);
      logic [31:0] w;
      w = 32'(a);
      word_of = {w[7:2], 2'b00};
   endfunction

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
         input logic [3:0] s);
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   // unknown strap codes fall back to the internal phy
   function automatic pmroc_mode_t to_mode(input logic [2:0] m);
      to_mode = (m > MODE_LAST) ? MODE_INTERNAL : pmroc_mode_t'(m);
   endfunction

   pmroc_mgmt_if mg ();

   // ==========================================================
   // pin synchronisers, core side
   logic [2:0] strap_meta, strap_sync;
   logic pol_meta, pol_sync;
   logic spd_meta, spd_sync;
   logic mdc_meta, mdc_sync;
   logic mdio_meta, mdio_sync;

   always_ff @(posedge core_clk) begin
      strap_meta <= port1_mode_strap;
      strap_sync <= strap_meta;
      pol_meta <= speed_pol_strap;
      pol_sync <= pol_meta;
      spd_meta <= port1_speed_in;
      spd_sync <= spd_meta;
      mdc_meta <= port1_mgmt_clock;
      mdc_sync <= mdc_meta;
      mdio_meta <= port1_mgmt_data_in;
      mdio_sync <= mdio_meta;
   end

   // ==========================================================
   // mode and strap capture
   pmroc_mode_t mode_reg;
   logic pol_reg;
   logic strap_done_reg;
   logic lpi_reg;
   logic do_write;
   logic [7:0] wr_word;
   logic [31:0] wr_data_reg;
   logic [3:0] wr_strb_reg;

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         mode_reg <= MODE_INTERNAL;
         pol_reg <= 1'b1;
         strap_done_reg <= 1'b0;
         lpi_reg <= 1'b0;
      end else if (ce) begin
         if (!strap_done_reg) begin
            mode_reg <= to_mode(strap_sync);
            pol_reg <= pol_sync;
            strap_done_reg <= 1'b1;
         end else if (do_write && wr_word == REG_CTRL) begin
            if (wr_strb_reg[0]) begin
               mode_reg <= to_mode(wr_data_reg[CTRL_MODE_LSB +: 3]);
               lpi_reg <= wr_data_reg[CTRL_LPI_BIT];
            end
         end
      end
   end

   // ==========================================================
   // speed selection
   logic speed_reg;
   logic auto_neg;
   assign auto_neg = mg.bc_value[BC_AN_BIT];

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         speed_reg <= 1'b0;
      end else if (ce) begin
         if (mode_reg == MODE_RMII_MAC && auto_neg) begin
            speed_reg <= ~(spd_sync ^ pol_reg);
         end else begin
            speed_reg <= mg.bc_value[BC_SPEED_BIT];
         end
      end
   end
   assign speed_100 = speed_reg;

   // ==========================================================
   // management slave hookup
   assign mg.mdc_s = mdc_sync;
   assign mg.mdio_s = mdio_sync;
   assign mg.active = (mode_reg == MODE_MII_PHY) || (mode_reg == MODE_RMII_PHY);
   assign mg.phy_addr = VPHY_ADDR;
   assign mg.sw_write = do_write && (wr_word == REG_VPHY_BC);
   assign mg.sw_data = merge16(mg.bc_value, wr_data_reg, wr_strb_reg);
   assign port1_mgmt_data_out = mg.mdio_out;
   assign port1_mgmt_data_oe = mg.mdio_oe;

   pmroc_vphy_mdio u_vphy (
      .core_clk(core_clk),
      .resetn(resetn),
      .ce(ce),
      .mg(mg.vphy)
   );

   // ==========================================================
   // axi4-lite write path; address and data taken in either order
   logic aw_held_reg, w_held_reg, bvalid_reg;
   logic [ADDR_W-1:0] awaddr_reg;
   logic [1:0] bresp_reg;
   logic wr_hit;

   assign wr_word = word_of(awaddr_reg);
   assign do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
   assign wr_hit = (wr_word == REG_CTRL) || (wr_word == REG_VPHY_BC);
   assign s_axi_awready = ~aw_held_reg;
   assign s_axi_wready = ~w_held_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
         awaddr_reg <= '0;
         wr_data_reg <= '0;
         wr_strb_reg <= '0;
      end else if (ce) begin
         if (s_axi_awvalid && !aw_held_reg) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_held_reg) begin
            w_held_reg <= 1'b1;
            wr_data_reg <= s_axi_wdata;
            wr_strb_reg <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_reg && s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   // ==========================================================
   // axi4-lite read path
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   logic [7:0] rd_word;
   logic [31:0] status_word;
   logic req_tgl_reg, ack_sync;

   assign rd_word = word_of(s_axi_araddr);
   assign s_axi_arready = ~rvalid_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   always_comb begin
      status_word = '0;
      status_word[STAT_MODE_LSB +: 3] = mode_reg;
      status_word[STAT_SPEED_BIT] = speed_reg;
      status_word[STAT_PIN_BIT] = spd_sync;
      status_word[STAT_POL_BIT] = pol_reg;
      status_word[STAT_MGMT_BUSY_BIT] = mg.busy;
      status_word[STAT_SYNCED_BIT] = (req_tgl_reg == ack_sync);
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= '0;
         rresp_reg <= RESP_OKAY;
      end else if (ce) begin
         if (s_axi_arvalid && !rvalid_reg) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= RESP_OKAY;
            case (rd_word)
               REG_CTRL: rdata_reg <= 32'({lpi_reg, mode_reg});
               REG_VPHY_BC: rdata_reg <= 32'(mg.bc_value);
               REG_STATUS: rdata_reg <= status_word;
               default: begin
                  rdata_reg <= '0;
                  rresp_reg <= RESP_SLVERR;
               end
            endcase
         end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

   // ==========================================================
   // control handover to the link domain by toggle handshake
   // xfer_reg is held still until the link side acknowledges
   logic [4:0] bundle;
   logic [4:0] xfer_reg;
   logic ack_meta;
   logic req_seen_reg;
   assign bundle = {mode_reg, mg.bc_value[BC_ISO_BIT], lpi_reg};

   always_ff @(posedge core_clk) begin
      ack_meta <= req_seen_reg;
      ack_sync <= ack_meta;
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         xfer_reg <= {MODE_INTERNAL, 1'b0, 1'b0};
         req_tgl_reg <= 1'b0;
      end else if (ce) begin
         if (req_tgl_reg == ack_sync && xfer_reg != bundle) begin
            xfer_reg <= bundle;
            req_tgl_reg <= ~req_tgl_reg;
         end
      end
   end

   // ==========================================================
   // link domain
   logic lrst_meta, lrst_n;
   logic lce_meta, lce;
   logic req_meta, req_sync;
   logic [4:0] lctl_reg;
   pmroc_mode_t lmode;
   logic liso, llpi, lmac, lphy, lmii_mac;

   always_ff @(posedge link_clk) begin
      lrst_meta <= resetn;
      lrst_n <= lrst_meta;
      lce_meta <= ce;
      lce <= lce_meta;
      req_meta <= req_tgl_reg;
      req_sync <= req_meta;
   end

   always_ff @(posedge link_clk) begin
      if (!lrst_n) begin
         req_seen_reg <= 1'b0;
         lctl_reg <= {MODE_INTERNAL, 1'b0, 1'b0};
      end else if (lce && req_sync != req_seen_reg) begin
         req_seen_reg <= req_sync;
         lctl_reg <= xfer_reg;
      end
   end

   assign lmode = pmroc_mode_t'(lctl_reg[4:2]);
   assign liso = lctl_reg[1];
   assign llpi = lctl_reg[0];
   assign lmac = (lmode == MODE_MII_MAC) || (lmode == MODE_RMII_MAC);
   assign lphy = (lmode == MODE_MII_PHY) || (lmode == MODE_RMII_PHY);
   assign lmii_mac = (lmode == MODE_MII_MAC);

   // ==========================================================
   // link pins; data and enables all registered
   always_ff @(posedge link_clk) begin
      if (!lrst_n) begin
         port1_out_valid <= 1'b0;
         port1_out_data <= IDLE_DATA;
         port1_out_error <= 1'b0;
      end else if (lce) begin
         port1_out_valid <= (lmac | lphy) & tx_valid;
         if ((lmac | lphy) && tx_valid) begin
            port1_out_data <= tx_data;
         end else if (lmii_mac && llpi) begin
            port1_out_data <= LPI_DATA;
         end else begin
            port1_out_data <= IDLE_DATA;
         end
         port1_out_error <= lmii_mac & (tx_valid ? tx_error : llpi);
      end
   end

   always_ff @(posedge link_clk) begin
      if (!lrst_n) begin
         port1_out_valid_oe <= 1'b0;
         port1_out_data_oe <= 1'b0;
         port1_out_error_oe <= 1'b0;
      end else if (lce) begin
         port1_out_valid_oe <= lmac | (lphy & ~liso);
         port1_out_data_oe <= lmac | (lphy & ~liso);
         port1_out_error_oe <= lmii_mac;
      end
   end

   // protection bits are accepted and ignored
   logic unused_prot;
   assign unused_prot = ^{s_axi_awprot, s_axi_arprot};
endmodule
`default_nettype wire

// [verification/pmroc_sideband_properties.sv]
// port-level checks for the sideband block
`timescale 1ns/10ps
`default_nettype none
module pmroc_sideband_props (
   // core domain
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic ce,
   // register slave
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   // link domain
   input wire logic link_clk,
   input wire logic tx_valid,
   input wire logic [3:0] tx_data,
   input wire logic port1_out_valid,
   input wire logic port1_out_valid_oe,
   input wire logic [3:0] port1_out_data,
   input wire logic port1_out_data_oe,
   input wire logic port1_out_error_oe
);
   // ====
   // register slave
   a_read_answer: assert property (@(posedge core_clk) disable iff (!resetn)
      ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
   a_read_stands: assert property (@(posedge core_clk) disable iff (!resetn)
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
      && $stable(s_axi_rresp)) else $error("read data moved");
   a_resp_stands: assert property (@(posedge core_clk) disable iff (!resetn)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response moved");
   a_read_refused: assert property (@(posedge core_clk) disable iff (!resetn)
      s_axi_rvalid |-> !s_axi_arready) else $error("second read accepted");
   // ====
   // link pins; isolate drops both oe together
   a_error_oe_mac: assert property (@(posedge link_clk) disable iff (!resetn)
      port1_out_error_oe |-> port1_out_valid_oe && port1_out_data_oe)
      else $error("error pin outside mac mode");
   a_oe_paired: assert property (@(posedge link_clk) disable iff (!resetn)
      port1_out_data_oe == port1_out_valid_oe) else $error("oe pair split");
   a_valid_follows: assert property (@(posedge link_clk) disable iff (!resetn)
      port1_out_valid_oe && $past(port1_out_valid_oe) |-> port1_out_valid == $past(tx_valid))
      else $error("valid pin lost the stream");
   a_data_follows: assert property (@(posedge link_clk) disable iff (!resetn)
      port1_out_valid && port1_out_valid_oe && $past(port1_out_valid_oe)
      |-> port1_out_data == $past(tx_data)) else $error("data pin lost the stream");
endmodule
bind pmroc_sideband pmroc_sideband_props u_props (.core_clk, .resetn, .ce, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_bresp, .link_clk, .tx_valid, .tx_data, .port1_out_valid,
   .port1_out_valid_oe, .port1_out_data, .port1_out_data_oe, .port1_out_error_oe);
`default_nettype wire

// [verification/pmroc_far_mgmt.sv]
// management master with line pull-up, the external mac
`timescale 1ns/10ps
`default_nettype none
module pmroc_far_mgmt import pmroc_pkg::*; #(
   parameter int HALF_NS = 800
) (
   // management pins
   output wire logic mdc,
   output wire logic line,
   input wire logic s_out,
   input wire logic s_oe
);
   logic mdc_r = 1'b0, m_oe = 1'b0, m_out = 1'b0;
   assign mdc = mdc_r;
   // released line falls back to the pull-up
   assign line = s_oe ? s_out : (m_oe ? m_out : 1'b1);
   // clock stands low between frames; slow half period covers the sync lag
   task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
         input logic [15:0] wd, output logic [15:0] rd);
      logic [63:0] bits;
      int k;
      bits = {32'hFFFF_FFFF, 2'b01, op, pa, ra, 2'b10, wd};
      rd = 16'h0000;
      #25;
      for (k = 63; k >= 0; k--) begin
         m_oe = !(op == OP_READ && k < 18);
         m_out = bits[k];
         #(HALF_NS) mdc_r = 1'b1;
         if (k < 16) rd[k] = line;
         #(HALF_NS) mdc_r = 1'b0;
      end
      m_oe = 1'b0;
   endtask
endmodule
`default_nettype wire

// [verification/tb_top.sv]
// self-checking bench for the sideband block
`timescale 1ns/10ps
`default_nettype none
module tb_top import pmroc_pkg::*;;
   logic core_clk = 0, link_clk = 0, resetn, ce;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [2:0] s_axi_awprot, s_axi_arprot, port1_mode_strap;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb, tx_data, port1_out_data;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [15:0] r;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, speed_pol_strap;
   logic port1_speed_in, speed_100, tx_valid, tx_error, port1_out_valid, port1_out_valid_oe;
   logic port1_out_data_oe, port1_out_error, port1_out_error_oe, port1_mgmt_clock;
   logic port1_mgmt_data_in, port1_mgmt_data_out, port1_mgmt_data_oe;
   int bad_count = 0, checks = 0, cycles = 0, seed = 74, m, p, i;
   pmroc_sideband u_dut (.core_clk, .resetn, .ce, .s_axi_awaddr, .s_axi_awprot,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .port1_mode_strap, .speed_pol_strap, .port1_speed_in, .speed_100, .link_clk, .tx_valid,
      .tx_data, .tx_error, .port1_out_valid, .port1_out_valid_oe, .port1_out_data,
      .port1_out_data_oe, .port1_out_error, .port1_out_error_oe, .port1_mgmt_clock,
      .port1_mgmt_data_in, .port1_mgmt_data_out, .port1_mgmt_data_oe);
   pmroc_far_mgmt u_far (.mdc(port1_mgmt_clock), .line(port1_mgmt_data_in),
      .s_out(port1_mgmt_data_out), .s_oe(port1_mgmt_data_oe));
   // ====
   // clocks; link edges off the core edges
   always #50 core_clk = ~core_clk;
   initial begin
      #1.5;
      forever #6 link_clk = ~link_clk;
   end
   // ====
   // helpers
   task automatic wait_c(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   function automatic logic [6:0] exp_pins(input int md, input logic [3:0] dat);
      if (md == 0 || md > 4) return 7'h00;
      return {1'b1, md == 1, 1'b1, dat};
   endfunction
   task automatic do_reset;
      resetn <= 1'b0;
      wait_c(8);
      resetn <= 1'b1;
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_awvalid === 1'b1 || s_axi_wvalid === 1'b1);
      repeat ($random(seed) & 3) @(posedge core_clk);
      s_axi_bready <= 1'b1;
      do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
      chk(s_axi_bresp, er);
      s_axi_bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge core_clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      repeat ($random(seed) & 3) @(posedge core_clk);
      s_axi_rready <= 1'b1;
      do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
      chk(s_axi_rdata, v);
      chk(s_axi_rresp, er);
      s_axi_rready <= 1'b0;
   endtask
   task automatic close_out;
      $display("bad_count=%0d checks=%0d", bad_count, checks);
      if (bad_count == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         close_out();
      end
   end
   // ====
   // scenarios
   initial begin
      {s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_araddr, s_axi_arprot, s_axi_arvalid, s_axi_rready, speed_pol_strap} = '0;
      {port1_speed_in, tx_valid, tx_data, tx_error, resetn} = '0;
      s_axi_wstrb = 4'hF;
      port1_mode_strap = 3'h1;
      ce = 1'b1;
      do_reset();
      axi_rd(REG_VPHY_BC, 32'h1000, RESP_OKAY);
      axi_rd(REG_CTRL, 32'h1, RESP_OKAY);
      axi_rd(8'h0C, 32'h0, RESP_SLVERR);
      axi_wr(8'h0C, 32'hFFFF, RESP_SLVERR);
      for (m = 0; m < 6; m++) begin
         axi_wr(REG_CTRL, 32'(m), RESP_OKAY);
         d = $random(seed);
         tx_valid <= 1'b1;
         tx_data <= d[3:0];
         wait_c(20);
         chk({port1_out_valid_oe, port1_out_error_oe, port1_out_valid, port1_out_data},
            exp_pins(m, d[3:0]));
         if (m == 2 || m == 4) begin
            axi_wr(REG_VPHY_BC, 32'h1400, RESP_OKAY);
            wait_c(20);
            chk({port1_out_valid_oe, port1_out_data_oe}, 2'h0);
            axi_wr(REG_VPHY_BC, 32'h1000, RESP_OKAY);
         end
      end
      axi_wr(REG_CTRL, 32'h9, RESP_OKAY);
      tx_valid <= 1'b0;
      wait_c(20);
      chk({port1_out_valid, port1_out_error, port1_out_data}, {2'b01, LPI_DATA});
      for (p = 0; p < 2; p++) begin
         speed_pol_strap <= p[0];
         do_reset();
         axi_wr(REG_CTRL, 32'h3, RESP_OKAY);
         for (i = 0; i < 2; i++) begin
            port1_speed_in <= i[0];
            wait_c(8);
            chk(speed_100, i[0] == p[0]);
         end
      end
      port1_speed_in <= 1'b0;
      axi_wr(REG_VPHY_BC, 32'h2000, RESP_OKAY);
      wait_c(8);
      chk(speed_100, 1'b1);
      port1_speed_in <= 1'b1;
      axi_wr(REG_VPHY_BC, 32'h0, RESP_OKAY);
      wait_c(8);
      chk(speed_100, 1'b0);
      axi_wr(REG_CTRL, 32'h2, RESP_OKAY);
      wait_c(20);
      u_far.frame(OP_WRITE, VPHY_ADDR_DEFAULT, VPHY_REG_BC, 16'h1400, r);
      axi_rd(REG_VPHY_BC, 32'h1400, RESP_OKAY);
      chk(port1_out_valid_oe, 1'b0);
      u_far.frame(OP_READ, VPHY_ADDR_DEFAULT, VPHY_REG_BC, 16'h0, r);
      chk(r, 16'h1400);
      u_far.frame(OP_WRITE, 5'h02, VPHY_REG_BC, 16'h1000, r);
      axi_rd(REG_VPHY_BC, 32'h1400, RESP_OKAY);
      chk(port1_mgmt_data_oe, 1'b0);
      close_out();
   end
endmodule
`default_nettype wire
